// ### adcss_top.sv
// Channel/reference selection and conversion sequencer with AXI4-Lite regs
// How it works
// [R01] Shadow channel/reference register is software read/write at any time.
// [R02] Shadow copied to applied while idle, only if converter enabled; frozen from conversion start.
// [R03] Copying resumes in final converter clock cycle before completion.
// [R04] Start bit write begins conversion at next converter clock edge.
// [R05] Software writes new selection at least one converter cycle after start.
// [R06] Software changes control only in the safe auto-trigger windows.
// [R07] Control settings take effect from the next conversion started.
// [R08] Free-running restart uses old channel; later conversions use new one.
// [R09] Input above reference yields full-scale code, never wraps.
// [R10] Reference is supply or internal bandgap-derived fixed reference.
// [R11] Software discards first result after a reference change.
// [R12] Sleep canceler needs enabled idle converter, single mode, interrupt on; sleep_go does not check ie_r.
// [R13] Noise or idle sleep with CPU halted starts a conversion; only the rising edge of sleep_noise_i starts one, there is no idle-sleep input.
// [R14] Sleep conversion end raises completion request even after other wake.
// [R15] Converter enable is not cleared on entry to any sleep mode.
// [R16] Result is input times 1024 over reference, 0x000 to 0x3FF.
// [R17] Result registers hold the result once completion flag is set.
// [R18] Reference select 0 picks supply, 1 picks internal reference.
// [R19] Six-bit channel split over two registers; codes 100000 up unconnected.
// [R20] Applied selection drives the multiplexer and reference switch.
// [R21] Shadow writes during conversion, before its final converter cycle, leave applied selection untouched.
`timescale 1ns/100ps
`include "adcss_defs.svh"
module adcss_top (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  // AXI4-Lite write
  input  wire logic [31:0]            s_axi_awaddr_i,
  input  wire logic                   s_axi_awvalid_i,
  output wire logic                   s_axi_awready_o,
  input  wire logic [31:0]            s_axi_wdata_i,
  input  wire logic [3:0]             s_axi_wstrb_i,
  input  wire logic                   s_axi_wvalid_i,
  output wire logic                   s_axi_wready_o,
  output logic      [1:0]             s_axi_bresp_o,
  output logic                        s_axi_bvalid_o,
  input  wire logic                   s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [31:0]            s_axi_araddr_i,
  input  wire logic                   s_axi_arvalid_i,
  output wire logic                   s_axi_arready_o,
  output logic      [31:0]            s_axi_rdata_o,
  output logic      [1:0]             s_axi_rresp_o,
  output logic                        s_axi_rvalid_o,
  input  wire logic                   s_axi_rready_i,
  // Converter core
  input  wire logic                   adc_tick_i,
  input  wire adcss_pkg::adcss_raw_t  core_code_i,
  output wire adcss_pkg::adcss_chan_t channel_o,
  output wire logic                   channel_valid_o,
  output wire logic                   reference_o,
  output wire logic                   converter_on_o,
  output logic                        sample_start_o,
  // Trigger, sleep and CPU request
  input  wire logic                   trigger_i,
  input  wire logic                   sleep_noise_i,
  output wire logic                   conv_irq_o
);
  import adcss_pkg::*;

  // ****************************************************************
  // Registers and selection path
  // ****************************************************************
  adcss_sel_if sel ();
  adcss_state_t state_r;
  adcss_state_t state_nxt;
  adcss_chan_t  shadow_ch_r;
  logic         shadow_ref_r;
  logic         en_r;
  logic         auto_r;
  logic         done_r;
  logic         ie_r;
  logic         free_r;
  logic         lock_r;
  logic         first_r;
  logic         trig_d_r;
  logic         sleep_d_r;
  logic [4:0]   cnt_r;
  adcss_code_t  result_r;
  adcss_code_t  sat_code;

  adcss_sel_latch u_latch (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .sel     (sel)
  );

  adcss_sat u_sat (
    .raw_i  (core_code_i),
    .code_o (sat_code)
  );

  assign sel.shadow_ch  = shadow_ch_r;
  assign sel.shadow_ref = shadow_ref_r;
  assign sel.lock       = lock_r;
  assign sel.enable     = en_r;

  // ****************************************************************
  // AXI4-Lite decode
  // ****************************************************************
  wire       wr_take  = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
  wire       rd_take  = s_axi_arvalid_i & ~s_axi_rvalid_o;
  wire [7:0] wr_idx   = s_axi_awaddr_i[9:2];
  wire [7:0] rd_idx   = s_axi_araddr_i[9:2];
  wire       wr_hit   = (s_axi_awaddr_i[31:10] == 22'h000000);
  wire       rd_hit   = (s_axi_araddr_i[31:10] == 22'h000000);
  wire       wr_lane  = s_axi_wstrb_i[0];
  wire [7:0] wd       = s_axi_wdata_i[7:0];
  wire       wr_ctrl  = wr_take & wr_hit & wr_lane &
                        (wr_idx == `ADCSS_IDX_CTRL);
  wire       wr_chlo  = wr_take & wr_hit & wr_lane &
                        (wr_idx == `ADCSS_IDX_CH_LO);
  wire       wr_chhi  = wr_take & wr_hit & wr_lane &
                        (wr_idx == `ADCSS_IDX_CH_HI);
  wire       wr_known = wr_hit & ((wr_idx == `ADCSS_IDX_CTRL) |
                        (wr_idx == `ADCSS_IDX_CH_LO) |
                        (wr_idx == `ADCSS_IDX_CH_HI) |
                        (wr_idx == `ADCSS_IDX_RES_LO) |
                        (wr_idx == `ADCSS_IDX_RES_HI));

  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o  = wr_take;
  assign s_axi_arready_o = rd_take;

  // ****************************************************************
  // Conversion sequencing
  // ****************************************************************
  wire busy      = (state_r == ADCSS_CONV);
  wire pending   = (state_r == ADCSS_WAIT);
  wire sw_start  = wr_ctrl & wd[`ADCSS_CTRL_START] & en_r & ~busy;
  wire trig_edge = trigger_i & ~trig_d_r;
  wire hw_trig   = en_r & auto_r & ~free_r & trig_edge & ~busy & ~done_r;
  wire sleep_go  = sleep_noise_i & ~sleep_d_r & en_r & ~auto_r &
                   ~busy & ~pending;
  wire begin_cv  = pending & adc_tick_i;
  wire complete  = busy & adc_tick_i & (cnt_r == 5'h01);
  wire restart   = complete & en_r & auto_r & free_r;
  wire done_clr  = wr_ctrl & wd[`ADCSS_CTRL_DONE];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADCSS_IDLE: begin
        if (sw_start | hw_trig | sleep_go) begin
          state_nxt = ADCSS_WAIT;   // R04 R13
        end
      end
      ADCSS_WAIT: begin
        if (!en_r) begin
          state_nxt = ADCSS_IDLE;
        end else if (adc_tick_i) begin
          state_nxt = ADCSS_CONV;   // R04
        end
      end
      ADCSS_CONV: begin
        if (!en_r) begin
          state_nxt = ADCSS_IDLE;
        end else if (complete) begin
          state_nxt = restart ? ADCSS_CONV : ADCSS_IDLE;  // R08
        end
      end
      default: state_nxt = ADCSS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state_r <= ADCSS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Conversion length, lock and completion
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_r    <= 5'h00;
      lock_r   <= 1'b0;
      first_r  <= 1'b1;
      result_r <= 10'h000;
      sample_start_o <= 1'b0;
    end else begin
      sample_start_o <= begin_cv | restart;
      if (!en_r) begin
        lock_r  <= 1'b0;
        first_r <= 1'b1;
      end else if (begin_cv | restart) begin
        cnt_r   <= first_r ? `ADCSS_CYC_FIRST : `ADCSS_CYC_NORMAL;
        lock_r  <= 1'b1;            // R02 R07
        first_r <= 1'b0;
      end else if (busy & adc_tick_i) begin
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == `ADCSS_CYC_LAST) begin
          lock_r <= 1'b0;           // R03
        end
      end
      if (complete) begin
        result_r <= sat_code;       // R17 R16
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      en_r   <= 1'b0;
      auto_r <= 1'b0;
      ie_r   <= 1'b0;
      free_r <= 1'b0;
      done_r <= 1'b0;
      shadow_ch_r  <= `ADCSS_CH_RST;
      shadow_ref_r <= `ADCSS_REF_RST;
      trig_d_r  <= 1'b0;
      sleep_d_r <= 1'b0;
    end else begin
      trig_d_r  <= trigger_i;
      sleep_d_r <= sleep_noise_i;
      if (wr_ctrl) begin
        en_r   <= wd[`ADCSS_CTRL_EN];   // R15
        auto_r <= wd[`ADCSS_CTRL_AUTO];
        ie_r   <= wd[`ADCSS_CTRL_IE];
        free_r <= wd[`ADCSS_CTRL_FREE];
      end
      if (complete) begin
        done_r <= 1'b1;             // R14
      end else if (done_clr) begin
        done_r <= 1'b0;
      end
      if (wr_chlo) begin
        shadow_ch_r[4:0] <= wd[4:0];    // R01 R19
      end
      if (wr_chhi) begin
        shadow_ch_r[5] <= wd[`ADCSS_CHHI_TOP];   // R19
        shadow_ref_r   <= wd[`ADCSS_CHHI_REF];   // R18
      end
    end
  end

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      `ADCSS_IDX_CTRL:   rd_byte = {en_r, busy | pending, auto_r, done_r,
                                    ie_r, 2'b00, free_r};
      `ADCSS_IDX_CH_LO:  rd_byte = {3'b000, shadow_ch_r[4:0]};
      `ADCSS_IDX_CH_HI:  rd_byte = {2'b00, shadow_ref_r, 4'h0,
                                    shadow_ch_r[5]};
      `ADCSS_IDX_RES_LO: rd_byte = result_r[7:0];
      `ADCSS_IDX_RES_HI: rd_byte = {6'h00, result_r[9:8]};
      default:           rd_byte = 8'h00;
    endcase
  end
  wire rd_known = rd_hit & ((rd_idx == `ADCSS_IDX_CTRL) |
                  (rd_idx == `ADCSS_IDX_CH_LO) |
                  (rd_idx == `ADCSS_IDX_CH_HI) |
                  (rd_idx == `ADCSS_IDX_RES_LO) |
                  (rd_idx == `ADCSS_IDX_RES_HI));

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `ADCSS_RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `ADCSS_RESP_OKAY;
      s_axi_rdata_o  <= 32'h00000000;
    end else begin
      if (wr_take) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? `ADCSS_RESP_OKAY : `ADCSS_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= rd_known ? `ADCSS_RESP_OKAY : `ADCSS_RESP_SLVERR;
        s_axi_rdata_o  <= {24'h000000, rd_known ? rd_byte : 8'h00};
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Core outputs
  // ****************************************************************
  assign channel_o       = sel.applied_ch;            // R20
  assign channel_valid_o = ~sel.applied_ch[5];        // R19
  assign reference_o     = sel.applied_ref;           // R10 R18
  assign converter_on_o  = en_r;
  assign conv_irq_o      = done_r & ie_r;             // R14

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_start_next_tick: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pending && adc_tick_i && en_r) |=> busy && lock_r && sample_start_o)
    else $error("conversion did not begin on converter edge"); // R04
  a_unlock_last: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (busy && adc_tick_i && cnt_r == 5'h02 && en_r) |=> !lock_r && busy)
    else $error("selection not reopened in final cycle"); // R03
  a_lock_in_conv: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (busy && cnt_r > 5'h02) |-> lock_r)
    else $error("selection open during conversion"); // R02
  a_done_result: assert property (@(posedge clock_i) disable iff (!nrst_i)
    complete |=> done_r && result_r == $past(sat_code))
    else $error("result or flag missing at completion"); // R17
  a_sat_clamp: assert property (@(posedge clock_i) disable iff (!nrst_i)
    core_code_i[10] |-> sat_code == 10'h3ff)
    else $error("over-range code wrapped"); // R09
  a_free_restart: assert property (@(posedge clock_i) disable iff (!nrst_i)
    restart |=> busy && lock_r && cnt_r == 5'h0f)
    else $error("free-running restart missing"); // R08
  a_sleep_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sleep_go |=> pending ##[0:300] (busy || !en_r))
    else $error("sleep conversion not started"); // R13
  a_irq_done: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (complete && ie_r && !wr_ctrl) |=> conv_irq_o)
    else $error("completion request not raised"); // R14
  a_ref_path: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (wr_chhi && !lock_r && en_r && !begin_cv && !restart) |=>
    ##1 reference_o == $past(wd[5], 2))
    else $error("reference select not applied"); // R18
endmodule

// ### adcss_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADCSS_DEFS_SVH
`define ADCSS_DEFS_SVH
// Register indices; byte address is four times the index
`define ADCSS_IDX_RES_LO    8'h78
`define ADCSS_IDX_RES_HI    8'h79
`define ADCSS_IDX_CTRL      8'h7a
`define ADCSS_IDX_CH_LO     8'h7c
`define ADCSS_IDX_CH_HI     8'h7d
// Control/status fields
`define ADCSS_CTRL_EN       7
`define ADCSS_CTRL_START    6
`define ADCSS_CTRL_AUTO     5
`define ADCSS_CTRL_DONE     4
`define ADCSS_CTRL_IE       3
`define ADCSS_CTRL_FREE     0
// Selection fields
`define ADCSS_CHHI_REF      5
`define ADCSS_CHHI_TOP      0
`define ADCSS_CH_RST        6'h00
`define ADCSS_REF_RST       1'b0
// Converter clock cycles per conversion, lock release count and full-scale code
`define ADCSS_CYC_FIRST     5'h1a
`define ADCSS_CYC_NORMAL    5'h0f
`define ADCSS_CYC_LAST      5'h02
`define ADCSS_CODE_MAX      10'h3ff
// Bus responses
`define ADCSS_RESP_OKAY     2'h0
`define ADCSS_RESP_SLVERR   2'h2
`endif

// ### adcss_pkg.sv
// Types shared by the sequencer modules
package adcss_pkg;
  typedef logic [5:0] adcss_chan_t;
  typedef logic [9:0] adcss_code_t;
  typedef logic [10:0] adcss_raw_t;
  typedef enum logic [1:0] {
    ADCSS_IDLE = 2'b00,
    ADCSS_WAIT = 2'b01,
    ADCSS_CONV = 2'b10
  } adcss_state_t;
endpackage

// ### adcss_sel_if.sv
// Selection path between sequencer control and applied selection latch
`timescale 1ns/100ps
interface adcss_sel_if;
  import adcss_pkg::*;
  adcss_chan_t shadow_ch;
  logic        shadow_ref;
  logic        lock;
  logic        enable;
  adcss_chan_t applied_ch;
  logic        applied_ref;
  modport ctl (output shadow_ch, shadow_ref, lock, enable,
               input applied_ch, applied_ref);
  modport latch (input shadow_ch, shadow_ref, lock, enable,
                 output applied_ch, applied_ref);
endinterface

// ### adcss_sel_latch.sv
// Applied channel and reference selection, fed from the shadow copy
`timescale 1ns/100ps
`include "adcss_defs.svh"
module adcss_sel_latch (
  // Clock and reset
  input  wire logic   clock_i,
  input  wire logic   nrst_i,
  // Selection path
  adcss_sel_if.latch  sel
);
  import adcss_pkg::*;
  wire copy_en = sel.enable & ~sel.lock;

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sel.applied_ch  <= `ADCSS_CH_RST;
      sel.applied_ref <= `ADCSS_REF_RST;
    end else if (copy_en) begin
      sel.applied_ch  <= sel.shadow_ch;    // R02
      sel.applied_ref <= sel.shadow_ref;
    end
  end

  a_applied_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sel.lock |=> $stable(sel.applied_ch) && $stable(sel.applied_ref))
    else $error("applied selection moved while locked"); // R21
  a_copy_open: assert property (@(posedge clock_i) disable iff (!nrst_i)
    copy_en |=> sel.applied_ch == $past(sel.shadow_ch))
    else $error("applied selection not copied while open"); // R02
endmodule

// ### adcss_sat.sv
// Clamps the core code to the ten-bit result range
`timescale 1ns/100ps
`include "adcss_defs.svh"
module adcss_sat (
  // Raw code in
  input  wire adcss_pkg::adcss_raw_t  raw_i,
  // Clamped code out
  output wire adcss_pkg::adcss_code_t code_o
);
  import adcss_pkg::*;
  wire over = raw_i[10];
  assign code_o = over ? `ADCSS_CODE_MAX : raw_i[9:0];  // R09 R16
endmodule

// ### adcss_core_model.sv
// Behavioural converter core: prescaled clock edges and sampled raw code
`timescale 1ns/100ps
module adcss_core_model #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   nrst_i,
  // Selection and control from the sequencer
  input  wire adcss_pkg::adcss_chan_t channel_i,
  input  wire logic                   reference_i,
  input  wire logic                   converter_on_i,
  input  wire logic                   sample_start_i,
  // Converter clock edge and raw result
  output logic                        adc_tick_o,
  output adcss_pkg::adcss_raw_t       core_code_o
);
  import adcss_pkg::*;
  int div_r;
  // Prescaler held in reset while the converter is off
  always_ff @(posedge clock_i) begin
    if (!nrst_i || !converter_on_i) begin
      div_r      <= 0;
      adc_tick_o <= 1'b0;
    end else begin
      div_r      <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
      adc_tick_o <= (div_r == TICK_DIV - 1);
    end
  end
  // Sample and hold of the applied input; channel 1f is driven over range
  always_ff @(posedge clock_i) begin
    if (!nrst_i)
      core_code_o <= '0;
    else if (sample_start_i)
      core_code_o <= (channel_i == 6'h1f) ? {1'b1, 10'h155}
                     : {1'b0, channel_i, reference_i, 3'h3};
  end
endmodule

// ### tb_adcss_top.sv
// Self-checking bench for the selection sequencer over its register bus
`timescale 1ns/100ps
`include "adcss_defs.svh"
module tb_adcss_top;
  import adcss_pkg::*;
  localparam logic [31:0] A_RLO = 32'(`ADCSS_IDX_RES_LO) * 4;
  localparam logic [31:0] A_RHI = 32'(`ADCSS_IDX_RES_HI) * 4;
  localparam logic [31:0] A_CTL = 32'(`ADCSS_IDX_CTRL) * 4;
  localparam logic [31:0] A_CLO = 32'(`ADCSS_IDX_CH_LO) * 4;
  localparam logic [31:0] A_CHI = 32'(`ADCSS_IDX_CH_HI) * 4;
  localparam logic [1:0]  OK    = `ADCSS_RESP_OKAY;
  localparam logic [1:0]  ER    = `ADCSS_RESP_SLVERR;
  logic        clock_i, nrst_i, awvalid, awready, wvalid, wready;
  logic        bvalid, bready, arvalid, arready, rvalid, rready;
  logic        tick, trig, sleep, irq, ch_valid, ref_sel, conv_on, smp;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0]  bresp, rresp;
  adcss_raw_t  raw;
  adcss_chan_t chan;
  int          n_mismatch, checked;

  adcss_top i_dut (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .adc_tick_i(tick), .core_code_i(raw),
    .channel_o(chan), .channel_valid_o(ch_valid), .reference_o(ref_sel),
    .converter_on_o(conv_on), .sample_start_o(smp), .trigger_i(trig),
    .sleep_noise_i(sleep), .conv_irq_o(irq)
  );

  adcss_core_model i_core (
    .clock_i(clock_i), .nrst_i(nrst_i), .channel_i(chan),
    .reference_i(ref_sel), .converter_on_i(conv_on),
    .sample_start_i(smp), .adc_tick_o(tick), .core_code_o(raw)
  );

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // ****************************************************************
  // Bus tasks and comparisons
  // ****************************************************************
  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] v,
                    input logic [1:0] er);
    logic [1:0] r;
    @(posedge clock_i);
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(negedge clock_i); while ((awready & wready) !== 1'b1);
    @(posedge clock_i);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(negedge clock_i); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clock_i);
    bready <= 1'b0;
    chk_resp(r, er);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clock_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge clock_i); while (arready !== 1'b1);
    @(posedge clock_i);
    arvalid <= 1'b0;
    do @(negedge clock_i); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    @(posedge clock_i);
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [7:0] ev,
                     input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    rd(a, v, r);
    chk_data(v, {24'h0, ev});
    chk_resp(r, er);
  endtask

  task automatic wait_done;
    logic [1:0] r;
    do rd(A_CTL, d, r); while (d[`ADCSS_CTRL_DONE] !== 1'b1);
  endtask

  task automatic chk_res(input logic [9:0] e);
    logic [31:0] lo, hi;
    logic [1:0]  r;
    rd(A_RLO, lo, r);
    rd(A_RHI, hi, r);
    chk_data({hi[23:0], lo[7:0]}, {22'h0, e});
  endtask

  function automatic logic [9:0] exp_code(input logic [5:0] c,
                                          input logic rf);
    return (c == 6'h1f) ? 10'h3ff : {c, rf, 3'h3};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    give_verdict;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {nrst_i, awvalid, wvalid, bready, arvalid, rready, trig, sleep} = '0;
    {awaddr, wdata, araddr} = '0;
    n_mismatch = 0;
    checked    = 0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdc(A_RLO + 32'(i * 4) + ((i > 2) ? 32'h4 : 32'h0), 8'h00, OK);
    @(negedge clock_i);
    chk_data({26'h0, chan}, 32'h0);
    chk_data({28'h0, ch_valid, ref_sel, conv_on, irq}, 32'h8);
    rdc(A_CTL + 32'h4, 8'h00, ER);
    wr(32'h400 | A_CTL, 8'hff, ER);
    rdc(A_CTL, 8'h00, OK);
    // Shadow is readable and writable; applied follows only when enabled
    wr(A_CHI, 8'hff, OK);
    wr(A_CLO, 8'hff, OK);
    rdc(A_CLO, 8'h1f, OK);
    rdc(A_CHI, 8'h21, OK);
    @(negedge clock_i);
    chk_data({26'h0, chan}, 32'h0);
    wr(A_CTL, 8'h80, OK);
    repeat (2) @(negedge clock_i);
    chk_data({26'h0, chan}, 32'h3f);
    chk_data({29'h0, ch_valid, ref_sel, conv_on}, 32'h3);
    // Single conversion with a shadow write in mid-conversion
    wr(A_CHI, 8'h00, OK);
    wr(A_CLO, 8'h05, OK);
    wr(A_CTL, 8'hc0, OK);
    do @(negedge clock_i); while (smp !== 1'b1);
    rdc(A_CTL, 8'hc0, OK);
    do @(negedge clock_i); while (tick !== 1'b1);
    wr(A_CLO, 8'h0a, OK);
    @(negedge clock_i);
    chk_data({26'h0, chan}, 32'h05);
    wait_done;
    chk_res(exp_code(6'h05, 1'b0));
    chk_data({26'h0, chan}, 32'h0a);
    // Input above reference is clamped to full scale
    wr(A_CLO, 8'h1f, OK);
    wr(A_CTL, 8'hd0, OK);
    wait_done;
    chk_res(10'h3ff);
    // Free running: channel change during an automatic restart
    wr(A_CLO, 8'h03, OK);
    wr(A_CTL, 8'hf1, OK);
    wait_done;
    wr(A_CLO, 8'h04, OK);
    chk_res(exp_code(6'h03, 1'b0));
    wr(A_CTL, 8'hb1, OK);
    wait_done;
    chk_res(exp_code(6'h03, 1'b0));
    wr(A_CTL, 8'hb1, OK);
    wait_done;
    chk_res(exp_code(6'h04, 1'b0));
    wr(A_CTL, 8'h10, OK);
    // Auto trigger on a rising edge
    wr(A_CLO, 8'h06, OK);
    wr(A_CTL, 8'hb0, OK);
    @(posedge clock_i);
    trig <= 1'b1;
    wait_done;
    trig <= 1'b0;
    chk_res(exp_code(6'h06, 1'b0));
    // Sleep conversion, then an early wake before completion
    wr(A_CLO, 8'h02, OK);
    wr(A_CTL, 8'h98, OK);
    @(posedge clock_i);
    sleep <= 1'b1;
    do @(negedge clock_i); while (irq !== 1'b1);
    chk_data({31'h0, conv_on}, 32'h1);
    @(posedge clock_i);
    sleep <= 1'b0;
    chk_res(exp_code(6'h02, 1'b0));
    wr(A_CLO, 8'h07, OK);
    wr(A_CTL, 8'h98, OK);
    @(negedge clock_i);
    chk_data({31'h0, irq}, 32'h0);
    @(posedge clock_i);
    sleep <= 1'b1;
    do @(negedge clock_i); while (smp !== 1'b1);
    @(posedge clock_i);
    sleep <= 1'b0;
    do @(negedge clock_i); while (irq !== 1'b1);
    chk_res(exp_code(6'h07, 1'b0));
    // Reference change: first result discarded, the next one checked
    wr(A_CHI, 8'h20, OK);
    @(negedge clock_i);
    chk_data({31'h0, ref_sel}, 32'h1);
    wr(A_CTL, 8'hd0, OK);
    wait_done;
    wr(A_CTL, 8'hd0, OK);
    wait_done;
    chk_res(exp_code(6'h07, 1'b1));
    give_verdict;
  end
endmodule
